//--- hssc_pkg.sv
// Purpose: Shared constants and types of the high-side switch control registers.
// Assumes: One 10 MHz clock; registers addressed by a 7-bit address.
// Notes: All offsets, field positions, reset values and timing counts live here.
package hssc_pkg;

	// ************************************************************
	// Clock and timing
	// ************************************************************
	localparam int CLK_HZ = 10_000_000;
	localparam int CLK_PERIOD_NS = 100;
	localparam int PWM_STEPS = 255;
	localparam int PWM_SLOW_HZ = 200;
	localparam int PWM_FAST_HZ = 400;
	// Clocks per duty step; the count rounds down so the period is never long.
	localparam int PWM_SLOW_TICKS = CLK_HZ / (PWM_SLOW_HZ * PWM_STEPS);
	localparam int PWM_FAST_TICKS = CLK_HZ / (PWM_FAST_HZ * PWM_STEPS);
	localparam int WAKE_FILTER_NS = 16_000;
	// Least filter time, rounded up to whole cycles.
	localparam int WAKE_FILTER_CYC = (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FO_SLOTS = 40;
	localparam int FO_SLOT_CYC = 250;
	localparam logic [5:0] FO_ON_20 = 6'h08;
	localparam logic [5:0] FO_ON_10 = 6'h04;
	localparam logic [5:0] FO_ON_5 = 6'h02;
	localparam logic [5:0] FO_ON_2P5 = 6'h01;

	// ************************************************************
	// Register offsets, masks and reset values
	// ************************************************************
	localparam logic [6:0] ADDR_SW_SHUTDOWN = 7'h10;
	localparam logic [6:0] ADDR_HS_SELECT_A = 7'h14;
	localparam logic [6:0] ADDR_HS_SELECT_B = 7'h15;
	localparam logic [6:0] ADDR_PIN_CONFIG = 7'h17;
	localparam logic [6:0] ADDR_PWM_DUTY_ONE = 7'h18;
	localparam logic [6:0] ADDR_PWM_DUTY_TWO = 7'h19;
	localparam logic [6:0] ADDR_PWM_FREQ = 7'h1c;
	localparam logic [7:0] SW_SHUTDOWN_MASK = 8'h70;
	localparam logic [7:0] RESET_VALUE = 8'h00;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int OVERVOLT_DISABLE_BIT = 6;
	localparam int UNDERVOLT_DISABLE_BIT = 5;
	localparam int RECOVERY_BIT = 4;
	localparam int SRC_LOW_POS = 0;
	localparam int SRC_HIGH_POS = 4;
	localparam int FO_DUTY_POS = 6;
	localparam int PIN_ONE_POS = 0;
	localparam int PIN_TWO_POS = 3;
	localparam int PWM_ONE_FREQ_BIT = 0;
	localparam int PWM_TWO_FREQ_BIT = 2;

	// ************************************************************
	// Encodings
	// ************************************************************
	typedef enum logic [2:0]
	{
		SRC_OFF = 3'b000,
		SRC_ON = 3'b001,
		SRC_TIMER_ONE = 3'b010,
		SRC_TIMER_TWO = 3'b011,
		SRC_PULSE_ONE = 3'b100,
		SRC_PULSE_TWO = 3'b101,
		SRC_RSVD_A = 3'b110,
		SRC_RSVD_B = 3'b111
	} hssc_src_t;

	typedef enum logic [2:0]
	{
		PIN_OFF = 3'b100,
		PIN_WAKE = 3'b101,
		PIN_LOW_SIDE = 3'b110,
		PIN_HIGH_SIDE = 3'b111
	} hssc_pin_t;

endpackage

//--- hssc_properties.sv
// Purpose: Concurrent checks on the switch control register block.
// Assumes: Only the ports of hssc_top are seen.
// Notes: The shutdown byte is mirrored from the writes seen at the port.
`timescale 1ns/1ns
module hssc_properties
	import hssc_pkg::*;
#(
	parameter int WAKE_CYC = WAKE_FILTER_CYC,
	parameter int FO_SLOT = FO_SLOT_CYC
)
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic soft_reset_i,
	input wire logic [6:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic supply_ov_i,
	input wire logic supply_uv_i,
	input wire logic [3:0] switch_overcurrent_i,
	input wire logic [3:0] switch_overtemp_i,
	input wire logic timer_one_ontime_set_i,
	input wire logic timer_one_active_o,
	input wire logic [3:0] switch_on_o,
	input wire logic [1:0] pin_low_side_on_o
);
	// ************************************************************
	// Shutdown mirror and checks
	// ************************************************************
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	logic [7:0] sd_reg;
	logic [7:0] sd_next;
	// Soft reset wins over a write, as in the block, so the mirror never drifts.
	always_comb
	begin
		sd_next = sd_reg;
		if (soft_reset_i)
			sd_next = 8'h00;
		else if (reg_wr_i && reg_addr_i == ADDR_SW_SHUTDOWN)
			sd_next = reg_wdata_i & SW_SHUTDOWN_MASK;
	end
	// The mirror only registers its next value.
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			sd_reg <= 8'h00;
		else
			sd_reg <= sd_next;
	end
	a_sd_rsvd_zero:
		assert property (reg_rd_i && reg_addr_i == ADDR_SW_SHUTDOWN |=> (reg_rdata_o & 8'h8f) == 8'h00)
		else $error("Shutdown reserved bits read as set.");
	a_sel_rsvd_zero:
		assert property (reg_rd_i && (reg_addr_i == ADDR_HS_SELECT_A || reg_addr_i == ADDR_HS_SELECT_B)
			|=> (reg_rdata_o & 8'h88) == 8'h00)
		else $error("Select reserved bits read as set.");
	a_unmapped_zero:
		assert property (reg_rd_i && reg_addr_i == 7'h00 |=> reg_rdata_o == 8'h00)
		else $error("Unmapped read not zero.");
	a_pin_rw_back:
		assert property ((reg_wr_i && reg_addr_i == ADDR_PIN_CONFIG && !soft_reset_i) ##1
			(!(reg_wr_i && reg_addr_i == ADDR_PIN_CONFIG) && !soft_reset_i) ##1
			(reg_rd_i && reg_addr_i == ADDR_PIN_CONFIG && !soft_reset_i)
			|=> reg_rdata_o == $past(reg_wdata_i, 3))
		else $error("Pin config read back differs.");
	a_ov_forces_off:
		assert property ((supply_ov_i && !sd_reg[OVERVOLT_DISABLE_BIT])[*3] |-> switch_on_o == 4'h0)
		else $error("Switch on during overvoltage.");
	a_uv_forces_off:
		assert property ((supply_uv_i && !sd_reg[UNDERVOLT_DISABLE_BIT])[*3] |-> switch_on_o == 4'h0)
		else $error("Switch on during undervoltage.");
	a_fault_clears_one:
		assert property (switch_overcurrent_i[0] || switch_overtemp_i[0] |-> ##2 !switch_on_o[0])
		else $error("Switch one on after its fault.");
	a_soft_reset_off:
		assert property (soft_reset_i |-> ##2 (switch_on_o == 4'h0 && pin_low_side_on_o == 2'h0))
		else $error("Outputs active after soft reset.");
	a_timer_needs_set:
		assert property (timer_one_active_o |-> $past(timer_one_ontime_set_i))
		else $error("Timer one active without on-time.");
endmodule
bind hssc_top hssc_properties #(.WAKE_CYC(WAKE_CYC), .FO_SLOT(FO_SLOT)) i_props (.*);

//--- hssc_pwm_gen.sv
// Purpose: One pulse generator with 255 duty steps and two frequencies.
// Assumes: Duty and frequency settings are synchronous levels.
// Notes: Duty 0 never turns on; duty 255 never turns off.
`timescale 1ns/1ns
module hssc_pwm_gen
	import hssc_pkg::*;
#(
	parameter int SLOW_TICKS = PWM_SLOW_TICKS,
	parameter int FAST_TICKS = PWM_FAST_TICKS
)
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	hssc_pwm_if.gen bus
);

	localparam int TW = $clog2(SLOW_TICKS + 1);

	// ************************************************************
	// Elaboration checks
	// ************************************************************
	if (FAST_TICKS < 1 || SLOW_TICKS < FAST_TICKS)
	begin : g_bad
		$error("Pulse generator tick counts out of range.");
	end

	logic [TW-1:0] tick_reg;
	logic [TW-1:0] tick_next;
	logic [7:0] step_reg;
	logic [7:0] step_next;
	logic out_reg;
	logic out_next;
	logic [TW-1:0] tick_last;

	// Step counter runs 0..254 so duty/255 is the on fraction.
	always_comb
	begin
		tick_last = bus.fast ? TW'(FAST_TICKS - 1) : TW'(SLOW_TICKS - 1);
		tick_next = tick_reg + TW'(1);
		step_next = step_reg;
		if (tick_reg >= tick_last)
		begin
			tick_next = '0;
			step_next = (step_reg >= 8'(PWM_STEPS - 1)) ? 8'h00 : step_reg + 8'h01; // R18
		end
		out_next = (step_reg < bus.duty); // R17
	end

	// Registers only.
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			tick_reg <= '0;
			step_reg <= 8'h00;
			out_reg <= 1'b0;
		end
		else
		begin
			tick_reg <= tick_next;
			step_reg <= step_next;
			out_reg <= out_next;
		end
	end

	assign bus.out = out_reg;

endmodule

//--- hssc_pwm_if.sv
// Purpose: Carries one pulse generator's settings and output.
// Assumes: Settings are levels held by the register file.
// Notes: The generator drives out; the register file drives duty and fast.
`timescale 1ns/1ns
interface hssc_pwm_if;
	logic [7:0] duty;
	logic fast;
	logic out;
	modport gen
	(
		input duty,
		input fast,
		output out
	);
	modport ctrl
	(
		output duty,
		output fast,
		input out
	);
endinterface

//--- hssc_timer_model.sv
// Purpose: Stands in for the two cyclic timers outside the block.
// Assumes: Levels move on the falling edge, away from the sampling edge.
// Notes: Periods 32 and 64 clocks, so each level holds for 16 clocks at least.
`timescale 1ns/1ns
module hssc_timer_model
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	output logic timer_one_o,
	output logic timer_two_o
);
	// ************************************************************
	// Free-running timer levels
	// ************************************************************
	logic [5:0] cnt_reg;
	// One counter gives both levels; their unequal periods keep them apart.
	always_ff @(negedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			cnt_reg <= 6'h00;
		else
			cnt_reg <= cnt_reg + 6'h01;
	end
	assign timer_one_o = cnt_reg[4];
	assign timer_two_o = cnt_reg[5];
endmodule

//--- hssc_top.sv
// Purpose: Control registers for four high-side switches and two general pins.
// Assumes: An upstream serial decoder presents one byte access per strobe.
// Notes: Timers and switch fault detectors sit outside and connect by level.
`timescale 1ns/1ns

// Notes on behaviour
// R01: Reserved bits in shutdown and switch registers read zero, ignore writes.
// R02: Shutdown bit 6 set disables switch-off on supply overvoltage.
// R03: Shutdown bit 5 set disables switch-off on supply undervoltage.
// R04: Bit 4 set restores previous switch state after supply fault; else stays off.
// R05: Four 3-bit source fields at bits 2:0 and 6:4 of two registers.
// R06: Source 000 off, 001 on, 010 timer one, 011 timer two.
// R07: Source 100 pulse one, 101 pulse two; 110 and 111 reserved.
// R08: Overcurrent or overtemperature clears that switch's source field.
// R09: All these registers reset to zero on power-on and soft reset.
// R10: Pin bits 7:6 pick output three duty: 20, 10, 5, 2.5 percent.
// R11: Pin one codes 000-011 give fixed output two, 100 off.
// R12: Pin two codes 000-011 give fixed output three, 100 off.
// R13: Code 101 makes the pin a wake input with 16 us filter.
// R14: Code 110 drives low-side switch on, 111 high-side switch on.
// R15: Software using cyclic sensing assigns that timer to a switch.
// R16: A timer runs once assigned to a switch and its on-time set.
// R17: Pulse duty value over 255 gives on fraction; 0 off, 255 on.
// R18: Pulse frequency bit 0 gives 200 Hz, 1 gives 400 Hz.
// R19: Enabled supply fault forces all four switches off while it lasts.
// R20: Fault clear of a source field beats a same-cycle software write.
module hssc_top
	import hssc_pkg::*;
#(
	parameter int WAKE_CYC = WAKE_FILTER_CYC,
	parameter int FO_SLOT = FO_SLOT_CYC
)
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic soft_reset_i,
	input wire logic [6:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire logic supply_ov_i,
	input wire logic supply_uv_i,
	input wire logic [3:0] switch_overcurrent_i,
	input wire logic [3:0] switch_overtemp_i,
	input wire logic cyc_timer_one_i,
	input wire logic cyc_timer_two_i,
	input wire logic timer_one_ontime_set_i,
	input wire logic timer_two_ontime_set_i,
	output logic timer_one_active_o,
	output logic timer_two_active_o,
	output logic [3:0] switch_on_o,
	input wire logic fixed_duty_output_two_i,
	input wire logic [1:0] pin_level_i,
	output logic [1:0] pin_high_side_on_o,
	output logic [1:0] pin_low_side_on_o,
	output logic [1:0] pin_wake_o
);

	localparam int WW = $clog2(WAKE_CYC + 1);
	localparam int FW = $clog2(FO_SLOT + 1);

	// ************************************************************
	// Elaboration checks
	// ************************************************************
	if (WAKE_CYC < 1 || FO_SLOT < 1)
	begin : g_bad
		$error("Filter or slot count must be at least one cycle.");
	end

	// ************************************************************
	// Functions
	// ************************************************************
	// Level a switch takes for a given source code.
	function automatic logic src_level(input logic [2:0] code, input logic t1, input logic t2,
		input logic [1:0] pw);
		logic lvl;
		case (hssc_src_t'(code))
			SRC_OFF: lvl = 1'b0; // R06
			SRC_ON: lvl = 1'b1; // R06
			SRC_TIMER_ONE: lvl = t1; // R06
			SRC_TIMER_TWO: lvl = t2; // R06
			SRC_PULSE_ONE: lvl = pw[0]; // R07
			SRC_PULSE_TWO: lvl = pw[1]; // R07
			default: lvl = 1'b0; // R07
		endcase
		return lvl;
	endfunction

	// On slots out of FO_SLOTS for each duty code of output three.
	function automatic logic [5:0] fo_on_slots(input logic [1:0] dc);
		logic [5:0] n;
		case (dc)
			2'b00: n = FO_ON_20; // R10
			2'b01: n = FO_ON_10; // R10
			2'b10: n = FO_ON_5; // R10
			default: n = FO_ON_2P5; // R10
		endcase
		return n;
	endfunction

	// ************************************************************
	// State
	// ************************************************************
	logic [7:0] shutdown_reg;
	logic [7:0] shutdown_next;
	logic [2:0] src_reg [4];
	logic [2:0] src_next [4];
	logic [7:0] pin_cfg_reg;
	logic [7:0] pin_cfg_next;
	logic [7:0] duty_reg [2];
	logic [7:0] duty_next [2];
	logic [1:0] freq_reg;
	logic [1:0] freq_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic [3:0] switch_reg;
	logic [3:0] switch_next;
	logic [1:0] tmr_act_reg;
	logic [1:0] tmr_act_next;
	logic [1:0] pwm_lvl;
	logic supply_fault;
	logic [3:0] switch_fault;

	// ************************************************************
	// Pulse generators
	// ************************************************************
	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_pwm
			hssc_pwm_if pwm_bus();
			assign pwm_bus.duty = duty_reg[g]; // R17
			assign pwm_bus.fast = freq_reg[g]; // R18
			assign pwm_lvl[g] = pwm_bus.out;
			hssc_pwm_gen u_gen
			(
				.clk_i(clk_i),
				.rst_n_i(rst_n_i),
				.bus(pwm_bus)
			);
		end
	endgenerate

	// ************************************************************
	// Register file and switch drive
	// ************************************************************
	// Supply fault counts only for the shutdowns that are left enabled.
	assign supply_fault = (supply_ov_i & ~shutdown_reg[OVERVOLT_DISABLE_BIT]) // R02
		| (supply_uv_i & ~shutdown_reg[UNDERVOLT_DISABLE_BIT]); // R03
	assign switch_fault = switch_overcurrent_i | switch_overtemp_i;

	// Writes are applied first so that a hardware clear overrides them.
	always_comb
	begin
		shutdown_next = shutdown_reg;
		pin_cfg_next = pin_cfg_reg;
		duty_next = duty_reg;
		freq_next = freq_reg;
		src_next = src_reg;
		rdata_next = rdata_reg;
		if (reg_wr_i)
		begin
			case (reg_addr_i)
				ADDR_SW_SHUTDOWN: shutdown_next = reg_wdata_i & SW_SHUTDOWN_MASK; // R01
				ADDR_HS_SELECT_A:
				begin
					src_next[0] = reg_wdata_i[SRC_LOW_POS +: 3]; // R05
					src_next[1] = reg_wdata_i[SRC_HIGH_POS +: 3]; // R05
				end
				ADDR_HS_SELECT_B:
				begin
					src_next[2] = reg_wdata_i[SRC_LOW_POS +: 3]; // R05
					src_next[3] = reg_wdata_i[SRC_HIGH_POS +: 3]; // R05
				end
				ADDR_PIN_CONFIG: pin_cfg_next = reg_wdata_i;
				ADDR_PWM_DUTY_ONE: duty_next[0] = reg_wdata_i;
				ADDR_PWM_DUTY_TWO: duty_next[1] = reg_wdata_i;
				ADDR_PWM_FREQ: freq_next = {reg_wdata_i[PWM_TWO_FREQ_BIT],
					reg_wdata_i[PWM_ONE_FREQ_BIT]};
				default: ;
			endcase
		end
		for (int i = 0; i < 4; i++)
		begin
			if (switch_fault[i])
			begin
				src_next[i] = SRC_OFF; // R08 R20
			end
			// Without recovery a supply fault drops the selection for good.
			if (supply_fault && !shutdown_reg[RECOVERY_BIT])
			begin
				src_next[i] = SRC_OFF; // R04
			end
		end
		if (reg_rd_i)
		begin
			case (reg_addr_i)
				ADDR_SW_SHUTDOWN: rdata_next = shutdown_reg & SW_SHUTDOWN_MASK; // R01
				ADDR_HS_SELECT_A: rdata_next = {1'b0, src_reg[1], 1'b0, src_reg[0]}; // R01
				ADDR_HS_SELECT_B: rdata_next = {1'b0, src_reg[3], 1'b0, src_reg[2]}; // R01
				ADDR_PIN_CONFIG: rdata_next = pin_cfg_reg;
				ADDR_PWM_DUTY_ONE: rdata_next = duty_reg[0];
				ADDR_PWM_DUTY_TWO: rdata_next = duty_reg[1];
				ADDR_PWM_FREQ: rdata_next = {5'h00, freq_reg[1], 1'b0, freq_reg[0]};
				default: rdata_next = 8'h00;
			endcase
		end
		if (soft_reset_i)
		begin
			shutdown_next = RESET_VALUE; // R09
			pin_cfg_next = RESET_VALUE; // R09
			duty_next = '{default: RESET_VALUE};
			freq_next = 2'b00;
			src_next = '{default: SRC_OFF}; // R09
		end
		// Outputs are forced low for the whole fault, whatever the selection.
		for (int i = 0; i < 4; i++)
		begin
			switch_next[i] = ~supply_fault & src_level(src_reg[i], cyc_timer_one_i, // R19
				cyc_timer_two_i, pwm_lvl);
		end
		tmr_act_next = 2'b00;
		for (int i = 0; i < 4; i++)
		begin
			if (src_reg[i] == SRC_TIMER_ONE)
			begin
				tmr_act_next[0] = timer_one_ontime_set_i; // R16
			end
			if (src_reg[i] == SRC_TIMER_TWO)
			begin
				tmr_act_next[1] = timer_two_ontime_set_i; // R16
			end
		end
	end

	// Registers only.
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			shutdown_reg <= RESET_VALUE; // R09
			pin_cfg_reg <= RESET_VALUE; // R09
			duty_reg <= '{default: RESET_VALUE};
			freq_reg <= 2'b00;
			src_reg <= '{default: SRC_OFF}; // R09
			rdata_reg <= 8'h00;
			switch_reg <= 4'h0;
			tmr_act_reg <= 2'b00;
		end
		else
		begin
			shutdown_reg <= shutdown_next;
			pin_cfg_reg <= pin_cfg_next;
			duty_reg <= duty_next;
			freq_reg <= freq_next;
			src_reg <= src_next;
			rdata_reg <= rdata_next;
			switch_reg <= switch_next;
			tmr_act_reg <= tmr_act_next;
		end
	end

	// ************************************************************
	// Fixed-duty output three and general pins
	// ************************************************************
	logic [FW-1:0] fo_tick_reg;
	logic [FW-1:0] fo_tick_next;
	logic [5:0] fo_slot_reg;
	logic [5:0] fo_slot_next;
	logic [WW-1:0] wcnt_reg [2];
	logic [WW-1:0] wcnt_next [2];
	logic [1:0] wake_reg;
	logic [1:0] wake_next;
	logic [1:0] phs_reg;
	logic [1:0] phs_next;
	logic [1:0] pls_reg;
	logic [1:0] pls_next;
	logic [1:0] fo_lvl;
	logic [2:0] mode [2];

	assign mode[0] = pin_cfg_reg[PIN_ONE_POS +: 3];
	assign mode[1] = pin_cfg_reg[PIN_TWO_POS +: 3];

	// Wake needs a full filter time of a steady new level before it changes.
	always_comb
	begin
		fo_tick_next = fo_tick_reg + FW'(1);
		fo_slot_next = fo_slot_reg;
		if (fo_tick_reg >= FW'(FO_SLOT - 1))
		begin
			fo_tick_next = '0;
			fo_slot_next = (fo_slot_reg >= 6'(FO_SLOTS - 1)) ? 6'h00 : fo_slot_reg + 6'h01;
		end
		fo_lvl[0] = fixed_duty_output_two_i; // R11
		fo_lvl[1] = fo_slot_reg < fo_on_slots(pin_cfg_reg[FO_DUTY_POS +: 2]); // R10 R12
		for (int p = 0; p < 2; p++)
		begin
			wake_next[p] = wake_reg[p];
			wcnt_next[p] = '0;
			phs_next[p] = 1'b0;
			pls_next[p] = 1'b0;
			case (mode[p])
				PIN_OFF: wake_next[p] = 1'b0; // R11 R12
				PIN_WAKE:
				begin
					if (pin_level_i[p] != wake_reg[p])
					begin
						wcnt_next[p] = wcnt_reg[p] + WW'(1);
						if (wcnt_reg[p] >= WW'(WAKE_CYC - 1))
						begin
							wake_next[p] = pin_level_i[p]; // R13
							wcnt_next[p] = '0;
						end
					end
				end
				PIN_LOW_SIDE:
				begin
					wake_next[p] = 1'b0;
					pls_next[p] = 1'b1; // R14
				end
				PIN_HIGH_SIDE:
				begin
					wake_next[p] = 1'b0;
					phs_next[p] = 1'b1; // R14
				end
				default:
				begin
					wake_next[p] = 1'b0;
					phs_next[p] = fo_lvl[p]; // R11 R12
				end
			endcase
		end
	end

	// Registers only.
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			fo_tick_reg <= '0;
			fo_slot_reg <= 6'h00;
			wcnt_reg <= '{default: '0};
			wake_reg <= 2'b00;
			phs_reg <= 2'b00;
			pls_reg <= 2'b00;
		end
		else
		begin
			fo_tick_reg <= fo_tick_next;
			fo_slot_reg <= fo_slot_next;
			wcnt_reg <= wcnt_next;
			wake_reg <= wake_next;
			phs_reg <= phs_next;
			pls_reg <= pls_next;
		end
	end

	assign reg_rdata_o = rdata_reg;
	assign switch_on_o = switch_reg;
	assign timer_one_active_o = tmr_act_reg[0];
	assign timer_two_active_o = tmr_act_reg[1];
	assign pin_high_side_on_o = phs_reg;
	assign pin_low_side_on_o = pls_reg;
	assign pin_wake_o = wake_reg;

endmodule

//--- tb_high_side_switch_control.sv
// Purpose: Self-checking bench for the switch control registers.
// Assumes: Inputs change on the falling edge; short wake and slot counts.
// Notes: Expected values come from the register layout, not the outputs.
`timescale 1ns/1ns
module tb_high_side_switch_control
	import hssc_pkg::*;
;
	// ************************************************************
	// Stimulus, tasks and sequence
	// ************************************************************
	localparam int WK = 4;
	localparam int FS = 2;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic soft_reset_i = 1'b0;
	logic [6:0] reg_addr_i = 7'h00;
	logic reg_wr_i = 1'b0;
	logic [7:0] reg_wdata_i = 8'h00;
	logic reg_rd_i = 1'b0;
	logic [7:0] reg_rdata_o;
	logic supply_ov_i = 1'b0;
	logic supply_uv_i = 1'b0;
	logic [3:0] switch_overcurrent_i = 4'h0;
	logic [3:0] switch_overtemp_i = 4'h0;
	logic cyc_timer_one_i;
	logic cyc_timer_two_i;
	logic timer_one_ontime_set_i = 1'b0;
	logic timer_two_ontime_set_i = 1'b0;
	logic timer_one_active_o;
	logic timer_two_active_o;
	logic [3:0] switch_on_o;
	logic fixed_duty_output_two_i = 1'b0;
	logic [1:0] pin_level_i = 2'h0;
	logic [1:0] pin_high_side_on_o;
	logic [1:0] pin_low_side_on_o;
	logic [1:0] pin_wake_o;
	int n_errors = 0;
	int checked = 0;
	int hi;
	logic e;
	logic [6:0] a;
	always #50 clk_i = ~clk_i;
	hssc_timer_model i_timers (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.timer_one_o(cyc_timer_one_i), .timer_two_o(cyc_timer_two_i));
	hssc_top #(.WAKE_CYC(WK), .FO_SLOT(FS)) i_dut (.*);
	task automatic tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One idle edge after each access keeps a strobe from rising as it drops.
	task automatic wr(input logic [6:0] ad, input logic [7:0] d);
		reg_wr_i = 1'b1;
		reg_addr_i = ad;
		reg_wdata_i = d;
		tick(1);
		reg_wr_i = 1'b0;
		tick(1);
	endtask
	// Read data is registered, so it is settled at the next falling edge.
	task automatic rd_chk(input logic [6:0] ad, input logic [7:0] exp);
		reg_rd_i = 1'b1;
		reg_addr_i = ad;
		tick(1);
		reg_rd_i = 1'b0;
		cmp("register", exp, reg_rdata_o);
		tick(1);
	endtask
	task automatic chk_zero();
		rd_chk(ADDR_SW_SHUTDOWN, 8'h00);
		rd_chk(ADDR_HS_SELECT_A, 8'h00);
		rd_chk(ADDR_HS_SELECT_B, 8'h00);
		rd_chk(ADDR_PIN_CONFIG, 8'h00);
		rd_chk(ADDR_PWM_FREQ, 8'h00);
	endtask
	function automatic logic src_exp(input logic [2:0] c);
		case (c)
			3'b001, 3'b100: return 1'b1;
			3'b010: return cyc_timer_one_i;
			3'b011: return cyc_timer_two_i;
			default: return 1'b0;
		endcase
	endfunction
	task automatic print_verdict();
		if (n_errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// A hung sequence counts as a mismatch and still reaches the verdict.
	initial
	begin
		repeat (20000) @(posedge clk_i);
		n_errors++;
		print_verdict();
	end
	// Main sequence: reset, layout, sources, faults, supply, timers, pins.
	initial
	begin
		tick(4);
		rst_n_i = 1'b1;
		chk_zero();
		wr(ADDR_SW_SHUTDOWN, 8'hff);
		rd_chk(ADDR_SW_SHUTDOWN, 8'h70);
		wr(ADDR_HS_SELECT_A, 8'hf9);
		rd_chk(ADDR_HS_SELECT_A, 8'h71);
		wr(ADDR_HS_SELECT_B, 8'hff);
		rd_chk(ADDR_HS_SELECT_B, 8'h77);
		wr(ADDR_PIN_CONFIG, 8'hf6);
		rd_chk(ADDR_PIN_CONFIG, 8'hf6);
		wr(ADDR_PWM_FREQ, 8'hff);
		rd_chk(ADDR_PWM_FREQ, 8'h05);
		wr(7'h00, 8'hff);
		rd_chk(7'h00, 8'h00);
		soft_reset_i = 1'b1;
		tick(1);
		soft_reset_i = 1'b0;
		chk_zero();
		// Duty two stays zero, so source 101 must look off and 100 on.
		wr(ADDR_PWM_DUTY_ONE, 8'hff);
		for (int c = 0; c < 8; c++)
		begin
			wr(ADDR_HS_SELECT_A, {1'b0, c[2:0], 1'b0, c[2:0]});
			wr(ADDR_HS_SELECT_B, {1'b0, c[2:0], 1'b0, c[2:0]});
			e = src_exp(c[2:0]);
			tick(3);
			if (e !== src_exp(c[2:0]))
			begin
				e = src_exp(c[2:0]);
				tick(3);
			end
			cmp("switches", {4'h0, {4{e}}}, {4'h0, switch_on_o});
		end
		// Each fault lands with a fresh write of the same register.
		for (int i = 0; i < 4; i++)
		begin
			a = (i < 2) ? ADDR_HS_SELECT_A : ADDR_HS_SELECT_B;
			switch_overcurrent_i[i] = !i[0];
			switch_overtemp_i[i] = i[0];
			wr(a, 8'h11);
			switch_overcurrent_i = 4'h0;
			switch_overtemp_i = 4'h0;
			rd_chk(a, i[0] ? 8'h01 : 8'h10);
		end
		tick(2);
		cmp("switches", 8'h05, {4'h0, switch_on_o});
		supply_ov_i = 1'b1;
		tick(3);
		cmp("switches", 8'h00, {4'h0, switch_on_o});
		supply_ov_i = 1'b0;
		tick(3);
		cmp("switches", 8'h00, {4'h0, switch_on_o});
		rd_chk(ADDR_HS_SELECT_A, 8'h00);
		wr(ADDR_SW_SHUTDOWN, 8'h10);
		wr(ADDR_HS_SELECT_A, 8'h11);
		supply_uv_i = 1'b1;
		tick(3);
		cmp("switches", 8'h00, {4'h0, switch_on_o});
		supply_uv_i = 1'b0;
		tick(3);
		cmp("switches", 8'h03, {4'h0, switch_on_o});
		wr(ADDR_SW_SHUTDOWN, 8'h60);
		supply_ov_i = 1'b1;
		supply_uv_i = 1'b1;
		tick(3);
		cmp("switches", 8'h03, {4'h0, switch_on_o});
		supply_ov_i = 1'b0;
		supply_uv_i = 1'b0;
		wr(ADDR_HS_SELECT_B, 8'h02);
		timer_one_ontime_set_i = 1'b1;
		timer_two_ontime_set_i = 1'b1;
		tick(2);
		cmp("timers", 8'h01, {6'h00, timer_two_active_o, timer_one_active_o});
		// A lone overtemperature pulse must drop switch one without any write.
		switch_overtemp_i = 4'h1;
		tick(1);
		switch_overtemp_i = 4'h0;
		tick(1);
		cmp("switch one", 8'h00, {7'h00, switch_on_o[0]});
		rd_chk(ADDR_HS_SELECT_A, 8'h10);
		for (int c = 0; c < 8; c++)
		begin
			fixed_duty_output_two_i = c[0];
			wr(ADDR_PIN_CONFIG, {2'b00, c[2:0], c[2:0]});
			tick(2);
			cmp("low side", {6'h00, {2{c == 6}}}, {6'h00, pin_low_side_on_o});
			if (c < 4)
				cmp("pin one", {7'h00, c[0]}, {7'h00, pin_high_side_on_o[0]});
			else
				cmp("high side", {6'h00, {2{c == 7}}}, {6'h00, pin_high_side_on_o});
		end
		wr(ADDR_PIN_CONFIG, 8'h2d);
		tick(2);
		pin_level_i = 2'b01;
		tick(WK - 2);
		cmp("wake", 8'h00, {6'h00, pin_wake_o});
		tick(3);
		cmp("wake", 8'h01, {6'h00, pin_wake_o});
		// Counting over a whole period makes the phase irrelevant.
		for (int d = 0; d < 4; d++)
		begin
			wr(ADDR_PIN_CONFIG, {d[1:0], 6'h04});
			tick(40 * FS);
			hi = 0;
			repeat (40 * FS)
			begin
				tick(1);
				hi += pin_high_side_on_o[1];
			end
			cmp("duty", 8'((8 >> d) * FS), hi[7:0]);
		end
		print_verdict();
	end
endmodule
